// [pes_buf.sv]
// Shared constants and types for the element status responder, and the
// two-entry output buffer that decouples the response stream from the host.
// Assumes a single clock domain with a synchronous active-high reset.
`default_nettype none

package pes_pkg;
    localparam int          N_ELEM       = 8;
    localparam int          IDX_W        = 3;
    localparam logic [7:0]  OPC_QUERY    = 8'h9E;
    localparam logic [4:0]  SA_QUERY     = 5'h17;
    localparam logic [1:0]  FILT_ALL     = 2'b00;
    localparam logic [1:0]  FILT_ATTN    = 2'b01;
    localparam logic [3:0]  RPT_ALL      = 4'h0;
    localparam logic [3:0]  RPT_STORAGE  = 4'h1;
    localparam logic [7:0]  TYPE_STORAGE = 8'h01;
    localparam logic [7:0]  HLTH_OUT_LO  = 8'h65;
    localparam logic [7:0]  HLTH_OUT_HI  = 8'hCF;
    localparam logic [7:0]  HLTH_DEP_ERR = 8'hFD;
    localparam logic [7:0]  HLTH_DEP_RUN = 8'hFE;
    localparam logic [7:0]  HLTH_DEP_OK  = 8'hFF;
    localparam logic [31:0] HDR_BYTES    = 32'h0000_0020;
    localparam logic [31:0] DESC_BYTES   = 32'h0000_0020;
    localparam int          DESC_SHIFT   = 5;
    localparam logic [3:0]  SK_ILLEGAL   = 4'h5;
    localparam logic [7:0]  ASC_BAD_OPC  = 8'h20;
    localparam logic [7:0]  ASC_BAD_CDB  = 8'h24;

    typedef enum logic [2:0] {
        PES_IDLE = 3'b001,
        PES_SEND = 3'b010,
        PES_DONE = 3'b100
    } pes_state_t;

    typedef struct packed {
        logic [31:0] id;
        logic [7:0]  etype;
        logic [7:0]  health;
        logic [63:0] capacity;
        logic        restore_ok;
    } pes_elem_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } pes_beat_t;

    typedef struct packed {
        logic [3:0]  sense_key;
        logic [7:0]  asc;
        logic        check;
    } pes_status_t;
endpackage : pes_pkg

module pes_buf (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire pes_pkg::pes_beat_t in_beat,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output pes_pkg::pes_beat_t    out_beat
);
    typedef struct packed {
        pes_pkg::pes_beat_t [1:0] mem;
        logic                     wp;
        logic                     rp;
        logic [1:0]               cnt;
    } pes_buf_t;

    pes_buf_t s_r;
    pes_buf_t s_nxt;
    logic     push;
    logic     pop;

    assign in_ready  = (s_r.cnt != 2'd2);
    assign out_valid = (s_r.cnt != 2'd0);
    assign out_beat  = s_r.mem[s_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_beat;
            s_nxt.wp          = ~s_r.wp;
        end
        if (pop)
        begin
            s_nxt.rp = ~s_r.rp;
        end
        // Simultaneous push and pop leaves the fill level unchanged
        if (push && !pop)
        begin
            s_nxt.cnt = s_r.cnt + 2'd1;
        end
        else if (pop && !push)
        begin
            s_nxt.cnt = s_r.cnt - 2'd1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule : pes_buf

`default_nettype wire

// [pes_responder.sv]
// Physical element status query handler: decodes a 16-byte command block,
// then streams the 32-byte header and the matching element descriptors, cut to the allocation length.
// Assumes the element table is written by local firmware logic on ref_clk
// and that the transport takes the byte stream with valid/ready.
`default_nettype none

module pes_responder (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Element table write port
    input  wire logic                  tab_we,
    input  wire logic [2:0]            tab_idx,
    input  wire pes_pkg::pes_elem_t    tab_elem,
    // Command block in
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire logic [127:0]          cmd_cdb,
    // Response byte stream out
    output logic                       rsp_valid,
    input  wire logic                  rsp_ready,
    output pes_pkg::pes_beat_t         rsp_beat,
    // Completion
    output logic                       done,
    output pes_pkg::pes_status_t       status
);
    typedef struct packed {
        pes_pkg::pes_state_t                    state;
        logic [31:0]                            start;
        logic [1:0]                             filt;
        logic [3:0]                             rpt;
        logic [31:0]                            len;
        logic [31:0]                            cnt;
        logic [31:0]                            thr;
        logic [31:0]                            total;
        logic [31:0]                            ret;
        logic [31:0]                            depop;
        // Set once the reply has been sized for the current command
        logic                                   sized;
        logic                                   done;
        pes_pkg::pes_status_t                   stat;
        pes_pkg::pes_elem_t [pes_pkg::N_ELEM-1:0] tab;
    } pes_core_t;

    pes_core_t                 s_r;
    pes_core_t                 s_nxt;
    logic [pes_pkg::N_ELEM-1:0] pass;
    logic                      buf_ready;
    logic                      push;
    pes_pkg::pes_beat_t        beat;

    // Live command fields
    logic [7:0]  c_opc;
    logic [4:0]  c_sa;
    logic [31:0] c_start;
    logic [31:0] c_alloc;
    logic [1:0]  c_filt;
    logic [1:0]  c_resv;
    logic [3:0]  c_rpt;

    assign c_opc   = cmd_cdb[127:120];
    assign c_sa    = cmd_cdb[116:112];
    assign c_start = cmd_cdb[79:48];
    assign c_alloc = cmd_cdb[47:16];
    assign c_filt  = cmd_cdb[15:14];
    assign c_resv  = cmd_cdb[13:12];
    assign c_rpt   = cmd_cdb[11:8];

    // Per-entry pass test against the latched report type and filter
    genvar g;
    generate
        for (g = 0; g < pes_pkg::N_ELEM; g++)
        begin : g_pass
            pes_pkg::pes_elem_t e;
            logic               type_ok;
            logic               hlth_ok;
            assign e       = s_r.tab[g];
            assign type_ok = (s_r.rpt == pes_pkg::RPT_ALL) ||
                             (e.etype == pes_pkg::TYPE_STORAGE);
            assign hlth_ok = (s_r.filt == pes_pkg::FILT_ALL) ||
                             ((e.health >= pes_pkg::HLTH_OUT_LO) &&
                              (e.health <= pes_pkg::HLTH_OUT_HI)) ||
                             (e.health >= pes_pkg::HLTH_DEP_ERR);
            // Identifier zero marks an unused slot
            assign pass[g] = (e.id != 32'h0000_0000) && type_ok && hlth_ok;
        end
    endgenerate

    // Smallest passing identifier at or above the cursor; the cursor only
    // moves after a descriptor's last byte, so the pick is stable meanwhile
    logic                    sel_found;
    logic [pes_pkg::IDX_W-1:0] sel_idx;
    always_comb
    begin
        sel_found = 1'b0;
        sel_idx   = '0;
        for (int i = 0; i < pes_pkg::N_ELEM; i++)
        begin
            if (pass[i] && (s_r.tab[i].id >= s_r.thr) &&
                (!sel_found || (s_r.tab[i].id < s_r.tab[sel_idx].id)))
            begin
                sel_found = 1'b1;
                sel_idx   = i[pes_pkg::IDX_W-1:0];
            end
        end
    end

    // Header and current descriptor images, byte 0 in the top lane
    logic [255:0] hdr_img;
    logic [255:0] dsc_img;
    pes_pkg::pes_elem_t cur;
    logic [31:0]  off;
    logic [4:0]   lane;
    assign cur     = s_r.tab[sel_idx];
    assign hdr_img = {s_r.total, s_r.ret, s_r.depop, 160'h0};
    assign dsc_img = {32'h0000_0000, cur.id, 47'h0, cur.restore_ok,
                      cur.etype, cur.health, cur.capacity, 64'h0};
    assign off     = s_r.cnt - pes_pkg::HDR_BYTES;
    assign lane    = (s_r.cnt < pes_pkg::HDR_BYTES) ? s_r.cnt[4:0] : off[4:0];

    always_comb
    begin
        beat.last = (s_r.cnt == s_r.len - 32'h0000_0001);
        if (s_r.cnt < pes_pkg::HDR_BYTES)
        begin
            beat.data = hdr_img[8'(255 - 8 * lane) -: 8];
        end
        else
        begin
            beat.data = dsc_img[8'(255 - 8 * lane) -: 8];
        end
    end

    assign push = (s_r.state == pes_pkg::PES_SEND) && buf_ready;

    // Counts over the whole table for a freshly latched command
    logic [31:0] n_total;
    logic [31:0] n_depop;
    logic [31:0] n_full;
    logic [31:0] n_fit;
    always_comb
    begin
        n_total = 32'h0000_0000;
        n_depop = 32'h0000_0000;
        for (int i = 0; i < pes_pkg::N_ELEM; i++)
        begin
            if (pass[i] && (s_r.tab[i].id >= s_r.start))
            begin
                n_total = n_total + 32'h0000_0001;
            end
            if ((s_r.tab[i].health == pes_pkg::HLTH_DEP_RUN) &&
                (n_depop == 32'h0000_0000))
            begin
                n_depop = s_r.tab[i].id;
            end
        end
        n_full = pes_pkg::HDR_BYTES + (n_total << pes_pkg::DESC_SHIFT);
        if (s_r.len < pes_pkg::HDR_BYTES)
        begin
            n_fit = 32'h0000_0000;
        end
        else
        begin
            n_fit = (s_r.len - pes_pkg::HDR_BYTES) >> pes_pkg::DESC_SHIFT;
        end
    end

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (tab_we)
        begin
            s_nxt.tab[tab_idx] = tab_elem;
        end
        case (s_r.state)
            pes_pkg::PES_IDLE:
            begin
                if (cmd_valid)
                begin
                    s_nxt.stat = '0;
                    s_nxt.start = c_start;
                    s_nxt.thr   = c_start;
                    s_nxt.filt  = c_filt;
                    s_nxt.rpt   = c_rpt;
                    s_nxt.len   = c_alloc;
                    s_nxt.cnt   = 32'h0000_0000;
                    s_nxt.sized = 1'b0;
                    if ((c_opc != pes_pkg::OPC_QUERY) || (c_sa != pes_pkg::SA_QUERY))
                    begin
                        s_nxt.stat.check     = 1'b1;
                        s_nxt.stat.sense_key = pes_pkg::SK_ILLEGAL;
                        s_nxt.stat.asc       = pes_pkg::ASC_BAD_OPC;
                        s_nxt.state          = pes_pkg::PES_DONE;
                    end
                    else if ((c_filt > pes_pkg::FILT_ATTN) || (c_resv != 2'b00) ||
                             (c_rpt > pes_pkg::RPT_STORAGE))
                    begin
                        s_nxt.stat.check     = 1'b1;
                        s_nxt.stat.sense_key = pes_pkg::SK_ILLEGAL;
                        s_nxt.stat.asc       = pes_pkg::ASC_BAD_CDB;
                        s_nxt.state          = pes_pkg::PES_DONE;
                    end
                    else
                    begin
                        s_nxt.state = pes_pkg::PES_SEND;
                    end
                end
            end
            pes_pkg::PES_SEND:
            begin
                if (!s_r.sized)
                begin
                    // One cycle to size the reply; counts use the table as it stands, tab_we writes still land
                    s_nxt.sized = 1'b1;
                    s_nxt.total = n_total;
                    s_nxt.depop = n_depop;
                    s_nxt.ret   = (n_fit < n_total) ? n_fit : n_total;
                    s_nxt.len   = (s_r.len < n_full) ? s_r.len : n_full;
                    if ((s_r.len == 32'h0000_0000))
                    begin
                        s_nxt.state = pes_pkg::PES_DONE;
                    end
                end
                else if (push)
                begin
                    s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                    if ((s_r.cnt >= pes_pkg::HDR_BYTES) && (lane == 5'd31))
                    begin
                        s_nxt.thr = cur.id + 32'h0000_0001;
                    end
                    if (beat.last)
                    begin
                        s_nxt.state = pes_pkg::PES_DONE;
                    end
                end
            end
            pes_pkg::PES_DONE:
            begin
                s_nxt.done  = 1'b1;
                s_nxt.state = pes_pkg::PES_IDLE;
            end
            default:
            begin
                s_nxt.state = pes_pkg::PES_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r       <= '0;
            s_r.state <= pes_pkg::PES_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Sizing cycle must not emit; the buffer sees pushes only once sized
    logic buf_in_valid;
    logic buf_ready_raw;
    assign buf_in_valid = push && s_r.sized;
    assign buf_ready    = buf_ready_raw && s_r.sized;

    pes_buf u_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_ready_raw),
        .in_beat   (beat),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_beat  (rsp_beat)
    );

    assign cmd_ready = (s_r.state == pes_pkg::PES_IDLE);
    assign done      = s_r.done;
    assign status    = s_r.stat;
endmodule : pes_responder

`default_nettype wire

// [pes_responder_props.sv]
// Port-level assertions for the element status responder.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none

module pes_chk (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // Command side
    input wire logic                 cmd_valid,
    input wire logic                 cmd_ready,
    input wire logic [127:0]         cmd_cdb,
    // Response side
    input wire logic                 rsp_valid,
    input wire logic                 rsp_ready,
    input wire pes_pkg::pes_beat_t   rsp_beat,
    input wire logic                 done,
    input wire pes_pkg::pes_status_t status
);
    logic tk;
    logic op_ok;
    logic fld_ok;
    logic no_len;
    assign tk = cmd_valid && cmd_ready;
    assign op_ok = cmd_cdb[127:120] == pes_pkg::OPC_QUERY
        && cmd_cdb[116:112] == pes_pkg::SA_QUERY;
    // Bits 5:4 of byte 14 are reserved, so they make a bad field too
    assign fld_ok = cmd_cdb[15:14] <= 2'b01 && cmd_cdb[13:12] == 2'b00
        && cmd_cdb[11:8] <= 4'h1;
    assign no_len = cmd_cdb[47:16] == 32'h0000_0000;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    bad_opcode_a: assert property (
        tk && !op_ok |-> ##1 !done ##1 (done && status.check
        && status.asc == pes_pkg::ASC_BAD_OPC)) else $error("opcode reject wrong");
    bad_field_a: assert property (
        tk && op_ok && !fld_ok |-> ##1 !done ##1 (done && status.check
        && status.asc == pes_pkg::ASC_BAD_CDB && status.sense_key == pes_pkg::SK_ILLEGAL))
        else $error("field reject wrong");
    zero_alloc_a: assert property (
        tk && op_ok && fld_ok && no_len |-> ##1 (!done) [*2] ##1 (done && !status.check))
        else $error("empty allocation timing wrong");
    sizing_gap_a: assert property (
        tk && op_ok && fld_ok && !no_len |-> ##1 (!done) [*2])
        else $error("accepted command ended too early");
    no_data_a: assert property (
        tk && !(op_ok && fld_ok) && !rsp_valid |=> (!rsp_valid) [*4])
        else $error("rejected command sent data");
    take_clear_a: assert property (
        tk |=> !cmd_ready && status.check == !$past(op_ok && fld_ok))
        else $error("take did not clear");
    done_pulse_a: assert property (
        done |-> cmd_ready ##1 !done) else $error("done not a single pulse");
    stall_hold_a: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_beat))
        else $error("stalled byte changed");
endmodule : pes_chk

bind pes_responder pes_chk u_chk (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_cdb  (cmd_cdb),
    .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready),
    .rsp_beat (rsp_beat),
    .done     (done),
    .status   (status)
);

`default_nettype wire

// [pes_host.sv]
// Initiator model: sinks the response stream, optionally stalling.
// Assumes the bench reads and clears got between commands.
`default_nettype none

module pes_host (
    // Clock and pacing
    input wire logic               ref_clk,
    input wire logic               slow,
    // Response stream
    input wire logic               rsp_valid,
    output logic                   rsp_ready,
    input wire pes_pkg::pes_beat_t rsp_beat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got [$];
    int         ph = 0;
    initial rsp_ready = 1'b0;
    // Slow mode takes one byte in three, so the two-entry buffer fills and holds
    always @(negedge ref_clk)
    begin
        ph <= ph + 1;
        rsp_ready <= !slow || ph % 3 == 0;
    end
    // Any descriptor count is taken; identical queries may differ
    always @(posedge ref_clk)
    begin
        if (rsp_valid && rsp_ready)
            got.push_back(rsp_beat);
    end
endmodule : pes_host

`default_nettype wire

// [pes_responder_tb.sv]
// Self-checking bench: table of queries, then a table change and a mid-run reset.
// Assumes pes_host as the initiator and the bound checker.
`default_nettype none

module pes_responder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  opc;
        logic [7:0]  sa;
        logic [7:0]  b14;
        logic [15:0] st;
        logic [15:0] al;
        logic [7:0]  asc;
    } pes_row_t;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 tab_we = 1'b0;
    logic [2:0]           tab_idx = 3'h0;
    pes_pkg::pes_elem_t   tab_elem = '0;
    logic                 cmd_valid = 1'b0;
    logic [127:0]         cmd_cdb = '0;
    logic                 slow = 1'b0;
    logic                 cmd_ready;
    logic                 rsp_valid;
    logic                 rsp_ready;
    logic                 done;
    pes_pkg::pes_beat_t   rsp_beat;
    pes_pkg::pes_status_t status;
    int                   failures = 0;
    int                   samples_checked = 0;
    logic [7:0] eid [8] = '{8'h1E, 8'h05, 8'h0C, 8'h00, 8'h28, 8'h07, 8'h14, 8'h03};
    logic [7:0] ety [8] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h01};
    logic [7:0] ehl [8] = '{8'h10, 8'h70, 8'hFE, 8'h00, 8'hFD, 8'hFF, 8'hD0, 8'hCF};
    logic [7:0] img [$];
    logic [8:0] exp_q [$];
    pes_row_t   rows [13] = '{
        '{8'h9E, 8'h17, 8'h00, 16'h0000, 16'h03E8, 8'h00},
        '{8'h9E, 8'h17, 8'h40, 16'h0000, 16'h03E8, 8'h00},
        '{8'h9E, 8'h17, 8'h41, 16'h0008, 16'h03E8, 8'h00},
        '{8'h9E, 8'h17, 8'h01, 16'h0007, 16'h0064, 8'h00},
        '{8'h9E, 8'h17, 8'h01, 16'h000D, 16'h0064, 8'h00},
        '{8'h9E, 8'h17, 8'h00, 16'h0000, 16'h0000, 8'h00},
        '{8'h9E, 8'h17, 8'h00, 16'h0000, 16'h0014, 8'h00},
        '{8'h9E, 8'h17, 8'h00, 16'h0029, 16'h03E8, 8'h00},
        '{8'h12, 8'h17, 8'h00, 16'h0000, 16'h03E8, 8'h20},
        '{8'h9E, 8'h16, 8'h00, 16'h0000, 16'h03E8, 8'h20},
        '{8'h9E, 8'h17, 8'h80, 16'h0000, 16'h03E8, 8'h24},
        '{8'h9E, 8'h17, 8'h02, 16'h0000, 16'h03E8, 8'h24},
        '{8'h9E, 8'h17, 8'h10, 16'h0000, 16'h03E8, 8'h24}};

    always #10 ref_clk = ~ref_clk;

    pes_responder dut (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tab_we   (tab_we),
        .tab_idx  (tab_idx),
        .tab_elem (tab_elem),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_cdb  (cmd_cdb),
        .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready),
        .rsp_beat (rsp_beat),
        .done     (done),
        .status   (status)
    );

    pes_host host (
        .ref_clk  (ref_clk),
        .slow     (slow),
        .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready),
        .rsp_beat (rsp_beat)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic tick(ref int n);
        @(negedge ref_clk);
        n++;
        if (n > 4000)
        begin
            failures++;
            close_out();
        end
    endtask : tick

    task automatic cmp_st(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: status got %h expected %h", $time, g, e);
        end
    endtask : cmp_st

    task automatic cmp_byte(input logic [8:0] g, input logic [8:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: byte got %h expected %h", $time, g, e);
        end
    endtask : cmp_byte

    function automatic bit keep(int i, logic [7:0] b);
        return eid[i] != 8'h00 && (b[7:6] == 2'b00 || (ehl[i] >= 8'h65 && ehl[i] <= 8'hCF)
            || ehl[i] >= 8'hFD) && (b[3:0] == 4'h0 || ety[i] == 8'h01);
    endfunction : keep

    task automatic load();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge ref_clk);
            tab_we = 1'b1;
            tab_idx = i[2:0];
            tab_elem = {24'h00_0000, eid[i], ety[i], ehl[i], 32'h0123_4567, 24'h00_0000,
                eid[i], eid[i][0]};
        end
        @(negedge ref_clk);
        tab_we = 1'b0;
    endtask : load

    // Reference stream: header then descriptors picked smallest id first
    task automatic build(input pes_row_t r);
        logic [255:0] hdr;
        logic [31:0]  lo;
        logic [31:0]  dep;
        int           pk;
        int           tot;
        int           ret;
        int           len;
        img = {};
        exp_q = {};
        lo = {16'h0000, r.st};
        dep = 32'h0000_0000;
        tot = 0;
        for (int i = 7; i >= 0; i--)
            if (ehl[i] == 8'hFE)
                dep = {24'h00_0000, eid[i]};
        do
        begin
            pk = -1;
            for (int i = 0; i < 8; i++)
                if (keep(i, r.b14) && eid[i] >= lo && (pk < 0 || eid[i] < eid[pk]))
                    pk = i;
            if (pk >= 0)
            begin
                tot++;
                lo = eid[pk] + 1;
                hdr = {56'h0, eid[pk], 32'h0, 8'h0, 7'h0, eid[pk][0], ety[pk], ehl[pk],
                    32'h0123_4567, 24'h00_0000, eid[pk], 64'h0};
                for (int b = 0; b < 32; b++)
                    img.push_back(hdr[255 - 8 * b -: 8]);
            end
        end
        while (pk >= 0);
        len = (r.al < 32 + 32 * tot) ? r.al : 32 + 32 * tot;
        ret = (r.al < 32) ? 0 : (r.al - 32) / 32;
        if (ret > tot)
            ret = tot;
        if (r.asc != 8'h00)
            len = 0;
        hdr = {32'(tot), 32'(ret), dep, 160'h0};
        for (int b = 0; b < len; b++)
            exp_q.push_back({b < 32 ? hdr[255 - 8 * b -: 8] : img[b - 32], b == len - 1});
    endtask : build

    task automatic issue(input pes_row_t r);
        int n;
        n = 0;
        build(r);
        host.got = {};
        while (cmd_ready !== 1'b1)
            tick(n);
        cmd_valid = 1'b1;
        cmd_cdb = {r.opc, r.sa, 48'h0, r.st, 16'h0000, r.al, r.b14, 8'h00};
        tick(n);
        cmd_valid = 1'b0;
        while (done !== 1'b1)
            tick(n);
        cmp_st({3'h0, r.asc != 8'h00 ? pes_pkg::SK_ILLEGAL : 4'h0, r.asc, r.asc != 8'h00},
            {3'h0, status});
        while (rsp_valid === 1'b1)
            tick(n);
        for (int i = 0; i < 400 && (i < exp_q.size() || i < host.got.size()); i++)
            cmp_byte(host.got[i], exp_q[i]);
    endtask : issue

    initial
    begin
        int n;
        n = 0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        cmp_st({cmd_ready, rsp_valid, done, status}, 16'h8000);
        load();
        foreach (rows[i])
        begin
            slow = i[0];
            issue(rows[i]);
            $display("row %0d finished", i);
        end
        ehl[0] = 8'hFE;
        load();
        issue(rows[1]);
        $display("table change finished");
        slow = 1'b1;
        cmd_valid = 1'b1;
        cmd_cdb = {rows[0].opc, rows[0].sa, 48'h0, 16'h0000, 16'h0000, rows[0].al, 16'h0000};
        tick(n);
        cmd_valid = 1'b0;
        repeat (40) @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        cmp_st({cmd_ready, rsp_valid, done, status}, 16'h8000);
        eid = '{default: 8'h00};
        issue(rows[0]);
        $display("mid reset finished");
        close_out();
    end
endmodule : pes_responder_tb

`default_nettype wire
